// [rtl/pssq_pkg.sv]
/*
  Package for the pack startup sequencer and gate turn-off block:
  timing figures, derived cycle counts, states and register map.
  Assumes a 200 MHz pclk; counts are derived from that rate.
*/
package pssq_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned CYC_PER_MS       = CLK_MHZ * 1000;
  localparam int unsigned T_REG_MS         = 20;
  localparam int unsigned T_STARTED_MS     = 23;
  localparam int unsigned T_INIT_DONE_MS   = 88;
  localparam int unsigned T_INIT_DONE_F_MS = 58;
  localparam int unsigned T_FULL_MS        = 221;
  localparam int unsigned T_FULL_F_MS      = 129;
  localparam int unsigned T_FET_MS         = 282;
  localparam int unsigned T_FET_F_MS       = 284;
  localparam int unsigned T_EVAL_MS        = 250;
  localparam int unsigned T_PULSE_MIN_US   = 100;
  localparam int unsigned T_PULSE_MAX_US   = 200;
  localparam int unsigned PULSE_MAX_CYC    = T_PULSE_MAX_US * CLK_MHZ;
  localparam int unsigned PULSE_MIN_CYC    = T_PULSE_MIN_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IRQ    = 12'h008;
  localparam logic [11:0] ADDR_MASK   = 12'h00C;
  localparam logic [11:0] ADDR_ALSEL  = 12'h010;
  localparam logic [11:0] ADDR_NVCFG  = 12'h014;

  // ctrl bits: 0 dsg off trigger (pulse), 1 chg off (held until the next FET turn-on decision)
  localparam int unsigned CTRL_DSG_OFF = 0;
  localparam int unsigned CTRL_CHG_OFF = 1;
  // nvcfg bits
  localparam int unsigned NV_FAST      = 0;
  localparam int unsigned NV_AUTO_SW   = 1;
  localparam int unsigned NV_REG_AUTO  = 2;
  localparam logic [2:0]  NVCFG_RESET  = 3'h7;
  // alarm flag bit positions
  localparam int unsigned AL_STARTED   = 0;
  localparam int unsigned AL_INIT_DONE = 1;
  localparam int unsigned AL_SCAN_DONE = 2;
  localparam int unsigned AL_FULL_DONE = 3;
  localparam int unsigned AL_W         = 4;
  localparam logic [3:0]  ALSEL_RESET  = 4'h_F;
  // irq event bits
  localparam int unsigned EV_WAKE      = 0;
  localparam int unsigned EV_FETS_ON   = 1;
  localparam int unsigned EV_DSG_DONE  = 2;
  localparam int unsigned EV_W         = 3;

  typedef enum logic [3:0] {
    PSSQ_SHUT  = 4'b0001,
    PSSQ_LOAD  = 4'b0010,
    PSSQ_START = 4'b0100,
    PSSQ_NORM  = 4'b1000
  } pssq_state_e;

endpackage

// [rtl/pssq_dsg_off.sv]
/*
  Discharge gate turn-off pulser: pulls the gate low while it sits
  above the load-sense level, then goes high impedance.
  Assumes comparator inputs are synchronous to pclk.
*/
`timescale 1ns/1ps
module pssq_dsg_off
  import pssq_pkg::*;
#(
  parameter int unsigned PULSE_CYC = PULSE_MAX_CYC
) (
  input  wire logic pclk,         // clock
  input  wire logic presetn,      // async reset, active low
  input  wire logic trigger,      // turn-off request pulse
  input  wire logic gate_above,   // gate above load-sense level
  input  wire logic gate_near,    // gate within 500 mV of load sense
  output logic      pull_down,    // discharge gate toward ground
  output logic      hiz,          // driver released
  output logic      done          // one-cycle end-of-pulsing pulse
);

  logic [31:0] cnt_reg;
  logic        act_reg;
  logic        pd_reg;
  logic        hiz_reg;
  logic        done_reg;
  wire         expired = act_reg && (cnt_reg == 32'h0000_0000);

  assign pull_down = pd_reg;
  assign hiz       = hiz_reg;
  assign done      = done_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= 32'h0000_0000;
      act_reg  <= 1'b0;
      pd_reg   <= 1'b0;
      hiz_reg  <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (trigger) begin
        act_reg <= 1'b1;
        pd_reg  <= 1'b1;
        hiz_reg <= 1'b0;
        cnt_reg <= PULSE_CYC;
      end else if (expired) begin
        pd_reg <= 1'b0;
        if (gate_near) begin
          act_reg  <= 1'b0;
          hiz_reg  <= 1'b1;
          done_reg <= 1'b1;
        end
      end else if (act_reg) begin
        cnt_reg <= cnt_reg - 32'h0000_0001;
        pd_reg  <= gate_above;
      end
    end
  end

endmodule

// [rtl/pssq_top.sv]
/*
  Pack startup sequencer: wake detect, timed startup steps, alarm
  pin, FET enable, charge and discharge gate turn-off, APB registers.
  Assumes APB master on pclk; analog comparators arrive as levels.
*/
`timescale 1ns/1ps
// Function
// - in shutdown, low thermistor pin or pulled-up load sense wakes the device
// - power the secondary regulator 20 ms after wake when configured
// - raise init-started flag 23 ms after wake
// - raise init-complete and scan-done together at 88 or 58 ms
// - raise full-scan-done at 221 or 129 ms
// - turn protection FETs on at 282 or 284 ms when enabled
// - FET-on decision also re-evaluated every 250 ms in normal mode
// - discharge gate turn-off begins by pulling the gate to ground
// - stop pulling once gate falls below load-sense level
// - resume pulling when gate rises again, forming a pulse train
// - pulse for 100 to 200 us, then high impedance near load sense
// - charge gate turn-off closes a switch toward stack top
// - alarm pin low while any selected flag active, else released
module pssq_top
  import pssq_pkg::*;
#(
  parameter int unsigned MS_CYC    = CYC_PER_MS,
  parameter int unsigned PULSE_CYC = PULSE_MAX_CYC
) (
  input  wire logic        pclk,                   // 200 MHz clock
  input  wire logic        presetn,                // async reset, active low
  input  wire logic        psel,                   // apb select
  input  wire logic        penable,                // apb access phase
  input  wire logic        pwrite,                 // apb direction
  input  wire logic [11:0] paddr,                  // apb byte address
  input  wire logic [31:0] pwdata,                 // apb write data
  output logic      [31:0] prdata,                 // apb read data
  output logic             pready,                 // apb ready
  output logic             pslverr,                // apb error
  input  wire logic        wake_thermistor_pin,    // thermistor pin level
  input  wire logic        load_sense_pin,         // load sense pulled up
  input  wire logic        nv_valid,               // nonvolatile data ready
  input  wire logic [2:0]  nv_cfg,                 // fast, autonomous_switch_enable, reg auto
  input  wire logic        dsg_gate_above,         // gate above load sense
  input  wire logic        dsg_gate_near,          // gate within 500 mV
  output logic             secondary_regulator,    // regulator enable
  output logic             fets_on,                // protection FETs on
  output logic             dsg_pull_down,          // discharge gate pull down
  output logic             dsg_hiz,                // discharge driver released
  output logic             chg_switch,             // charge gate switch closed
  output logic             alarm_n_oe,             // alarm pin drives low
  output logic             irq                     // interrupt, active high
);

  // ----------------------------------------------------------------
  // state and timers
  // ----------------------------------------------------------------
  pssq_state_e state_reg;
  pssq_state_e state_next;
  logic [31:0] ms_div_reg;
  logic [15:0] ms_reg;
  logic [15:0] eval_reg;
  logic [2:0]  cfg_reg;
  logic [AL_W-1:0] flags_reg;
  logic [AL_W-1:0] alsel_reg;
  logic [EV_W-1:0] sts_reg;
  logic [EV_W-1:0] mask_reg;
  logic        reg_on_reg;
  logic        fet_reg;
  logic        chg_reg;
  logic        dsg_trig_reg;
  logic        alarm_reg;
  logic        irq_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        dsg_pd;
  logic        dsg_hz;
  logic        dsg_done;

  // ms tick counting from the wake
  function automatic logic at_ms(input logic [15:0] now, input int unsigned t);
    at_ms = (now == t[15:0]);
  endfunction

  wire ms_tick  = (ms_div_reg == MS_CYC - 1);
  // write strobes; a write lands in the access cycle only
  wire acc      = psel && penable;
  wire wr       = acc && pwrite;
  wire pwr_ctrl = wr && (paddr == ADDR_CTRL);
  wire wr_irq   = wr && (paddr == ADDR_IRQ);
  wire wr_mask  = wr && (paddr == ADDR_MASK);
  wire wr_alsel = wr && (paddr == ADDR_ALSEL);
  wire wake     = (state_reg == PSSQ_SHUT) && (!wake_thermistor_pin || load_sense_pin);
  wire fast     = cfg_reg[NV_FAST];
  wire t_init   = fast ? at_ms(ms_reg, T_INIT_DONE_F_MS) : at_ms(ms_reg, T_INIT_DONE_MS);
  wire t_full   = fast ? at_ms(ms_reg, T_FULL_F_MS) : at_ms(ms_reg, T_FULL_MS);
  wire [15:0] t_fet_ms = fast ? 16'(T_FET_F_MS) : 16'(T_FET_MS);
  wire fet_due  = ms_tick && (ms_reg == t_fet_ms - 16'h0001);
  wire eval_due = ms_tick && (eval_reg == 16'(T_EVAL_MS - 1));
  // fets wait for the full scan so the decision sees fresh data
  wire fet_go   = cfg_reg[NV_AUTO_SW] && !fet_reg && flags_reg[AL_FULL_DONE]
                  && (fet_due || eval_due);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PSSQ_SHUT:  if (wake) state_next = PSSQ_LOAD;
      PSSQ_LOAD:  if (nv_valid) state_next = PSSQ_START;
      PSSQ_START: if (flags_reg[AL_FULL_DONE]) state_next = PSSQ_NORM;
      PSSQ_NORM:  state_next = PSSQ_NORM;
      default:    state_next = PSSQ_SHUT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= PSSQ_SHUT;
      ms_div_reg <= 32'h0000_0000;
      ms_reg     <= 16'h0000;
      eval_reg   <= 16'h0000;
      cfg_reg    <= NVCFG_RESET;
    end else begin
      state_reg <= state_next;
      if (state_reg == PSSQ_LOAD && nv_valid) begin
        cfg_reg <= nv_cfg;
      end
      // wake is time zero; load time counts toward the schedule
      if (state_reg == PSSQ_SHUT) begin
        ms_div_reg <= 32'h0000_0000;
        ms_reg     <= 16'h0000;
      end else if (ms_tick) begin
        ms_div_reg <= 32'h0000_0000;
        ms_reg     <= (ms_reg == 16'h_FFFF) ? ms_reg : ms_reg + 16'h0001;
      end else begin
        ms_div_reg <= ms_div_reg + 32'h0000_0001;
      end
      if (state_reg != PSSQ_NORM || eval_due) begin
        eval_reg <= 16'h0000;
      end else if (ms_tick) begin
        eval_reg <= eval_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // flags and drivers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg  <= '0;
      reg_on_reg <= 1'b0;
      fet_reg    <= 1'b0;
      chg_reg    <= 1'b0;
    end else begin
      if (state_reg == PSSQ_SHUT) begin
        flags_reg  <= '0;
        reg_on_reg <= 1'b0;
        fet_reg    <= 1'b0;
      end else begin
        if (cfg_reg[NV_REG_AUTO] && ms_reg >= 16'(T_REG_MS)) reg_on_reg <= 1'b1;
        if (ms_reg >= 16'(T_STARTED_MS)) flags_reg[AL_STARTED] <= 1'b1;
        if (t_init) begin
          flags_reg[AL_INIT_DONE] <= 1'b1;
          flags_reg[AL_SCAN_DONE] <= 1'b1;
        end
        if (t_full) flags_reg[AL_FULL_DONE] <= 1'b1;
        if (fet_go) fet_reg <= 1'b1;
        // any turn-off request beats a pending turn-on
        if (dsg_trig_reg || chg_reg) fet_reg <= 1'b0;
      end
      if (pwr_ctrl && pwdata[CTRL_CHG_OFF]) begin
        chg_reg <= 1'b1;
      end else if (fet_go) begin
        chg_reg <= 1'b0;
      end
    end
  end

  pssq_dsg_off #(
    .PULSE_CYC (PULSE_CYC)
  ) u_dsg (
    .pclk       (pclk),
    .presetn    (presetn),
    .trigger    (dsg_trig_reg),
    .gate_above (dsg_gate_above),
    .gate_near  (dsg_gate_near),
    .pull_down  (dsg_pd),
    .hiz        (dsg_hz),
    .done       (dsg_done)
  );

  // ----------------------------------------------------------------
  // apb slave, interrupts, alarm
  // ----------------------------------------------------------------
  // read decode; ctrl is write-only and unmapped offsets read zero
  logic [31:0] rd_mux;
  logic        hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    hit    = 1'b1;
    if (paddr == ADDR_CTRL) begin
      rd_mux = 32'h0000_0000;
    end else if (paddr == ADDR_STATUS) begin
      rd_mux = {20'h0_0000, 1'b0, fet_reg, reg_on_reg, chg_reg, state_reg, flags_reg};
    end else if (paddr == ADDR_IRQ) begin
      rd_mux = {29'h0000_0000, sts_reg};
    end else if (paddr == ADDR_MASK) begin
      rd_mux = {29'h0000_0000, mask_reg};
    end else if (paddr == ADDR_ALSEL) begin
      rd_mux = {28'h000_0000, alsel_reg};
    end else if (paddr == ADDR_NVCFG) begin
      rd_mux = {29'h0000_0000, cfg_reg};
    end else begin
      hit    = 1'b0;
    end
  end
  wire [EV_W-1:0] ev = {dsg_done, fet_go, wake};
  wire [EV_W-1:0] clr = wr_irq ? pwdata[EV_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg   <= 32'h0000_0000;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      sts_reg      <= '0;
      mask_reg     <= '0;
      alsel_reg    <= ALSEL_RESET;
      dsg_trig_reg <= 1'b0;
      alarm_reg    <= 1'b0;
      irq_reg      <= 1'b0;
    end else begin
      pready_reg   <= psel && !penable;
      pslverr_reg  <= psel && !penable && !hit;
      prdata_reg   <= rd_mux;
      dsg_trig_reg <= pwr_ctrl && pwdata[CTRL_DSG_OFF];
      // set beats clear
      sts_reg      <= (sts_reg & ~clr) | ev;
      if (wr_mask) mask_reg <= pwdata[EV_W-1:0];
      if (wr_alsel) alsel_reg <= pwdata[AL_W-1:0];
      alarm_reg    <= |(flags_reg & alsel_reg);
      irq_reg      <= |(sts_reg & mask_reg);
    end
  end

  assign prdata              = prdata_reg;
  assign pready              = pready_reg;
  assign pslverr             = pslverr_reg;
  assign secondary_regulator = reg_on_reg;
  assign fets_on             = fet_reg;
  assign dsg_pull_down       = dsg_pd;
  assign dsg_hiz             = dsg_hz;
  assign chg_switch          = chg_reg;
  assign alarm_n_oe          = alarm_reg;
  assign irq                 = irq_reg;

endmodule

// [verification/pssq_assertions.sv]
/*
  Concurrent checks on the startup sequencer's ports.
  Assumes one pclk domain with presetn as async active-low reset.
*/
`timescale 1ns/1ps
module pssq_assertions #(
  parameter int unsigned PULSE_CYC = 40000
) (
  input wire logic pclk,                 // clock
  input wire logic presetn,              // reset, active low
  input wire logic psel,                 // apb select
  input wire logic penable,              // apb access
  input wire logic pready,               // apb ready
  input wire logic pslverr,              // apb error
  input wire logic secondary_regulator,  // regulator enable
  input wire logic fets_on,              // fets on
  input wire logic chg_switch,           // charge switch
  input wire logic dsg_pull_down,        // gate pull down
  input wire logic dsg_hiz,              // driver released
  input wire logic dsg_gate_near         // gate near load sense
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  int unsigned run_reg;
  // cycles since driver left high impedance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_reg <= 0;
    else if (dsg_hiz) run_reg <= 0;
    else run_reg <= run_reg + 1;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no zero-wait answer");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_pull_not_hiz: assert property (dsg_pull_down |-> !dsg_hiz)
    else $error("pull down while released");
  a_hiz_near: assert property ($rose(dsg_hiz) |-> $past(dsg_gate_near))
    else $error("released while gate far");
  a_pulse_bound: assert property (dsg_pull_down |-> run_reg <= PULSE_CYC + 4)
    else $error("pulsing too long");
  a_chg_drops: assert property ($rose(chg_switch) |-> ##[0:1] !fets_on)
    else $error("fets stay on at charge off");
  a_reg_holds: assert property (secondary_regulator |=> secondary_regulator)
    else $error("regulator dropped");
endmodule
bind pssq_top pssq_assertions #(.PULSE_CYC(PULSE_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .secondary_regulator(secondary_regulator),
  .fets_on(fets_on), .chg_switch(chg_switch), .dsg_pull_down(dsg_pull_down),
  .dsg_hiz(dsg_hiz), .dsg_gate_near(dsg_gate_near));

// [verification/pssq_gate_model.sv]
/*
  Discharge FET gate model with its comparators against load sense.
  Assumes gate starts fully charged; levels are abstract units.
*/
`timescale 1ns/1ps
module pssq_gate_model (
  input  wire logic pclk,        // clock
  input  wire logic presetn,     // reset, active low
  input  wire logic pull_down,   // driver pulls gate
  output logic      gate_above,  // gate above load sense
  output logic      gate_near    // gate within margin
);
  // ----------------------------------------------------------------
  // gate level
  // ----------------------------------------------------------------
  localparam int LOAD_LVL = 20;
  int v;
  // gate relaxes upward once released below load sense, forcing pulses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) v <= 100;
    else if (pull_down) v <= v - 8;
    else if (v <= LOAD_LVL) v <= v + 3;
  end
  assign gate_above = v > LOAD_LVL;
  assign gate_near  = (v <= LOAD_LVL + 5) && (v >= LOAD_LVL - 5);
endmodule

// [verification/pssq_tb.sv]
/*
  Self-checking bench for the startup sequencer and gate turn-off.
  Assumes shortened counts: MS_CYC 20, PULSE_CYC 50.
*/
`timescale 1ns/1ps
module testbench;
  import pssq_pkg::*;
  localparam int unsigned MS = 20;
  localparam int unsigned PW = 50;
  logic        pclk, presetn, psel, penable, pwrite, therm, lsense, nv_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, above, near, reg_en, fets_on, pull, hiz, charge_gate_drive;
  logic        alarm_oe, irq, err;
  logic [2:0]  nv_cfg;
  int          miscompares = 0, num_checks = 0, cyc = 0, wake_at = 0;
  wire  [2:0]  obs = {fets_on, alarm_oe, reg_en};
  pssq_top #(.MS_CYC(MS), .PULSE_CYC(PW)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_thermistor_pin(therm),
    .load_sense_pin(lsense), .nv_valid(nv_valid), .nv_cfg(nv_cfg),
    .dsg_gate_above(above), .dsg_gate_near(near), .secondary_regulator(reg_en),
    .fets_on(fets_on), .dsg_pull_down(pull), .dsg_hiz(hiz), .chg_switch(charge_gate_drive),
    .alarm_n_oe(alarm_oe), .irq(irq));
  pssq_gate_model u_gate (.pclk(pclk), .presetn(presetn), .pull_down(pull),
    .gate_above(above), .gate_near(near));
  // ----------------------------------------------------------------
  // clock, timeout, shared tasks
  // ----------------------------------------------------------------
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 40000) begin
      miscompares++;
      wrap_up();
    end
  end
  task wrap_up;
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task do_reset(input logic [2:0] cfg);
    presetn <= 0; nv_cfg <= cfg; therm <= 1; lsense <= 0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
  endtask
  task wake(input logic by_ld);
    if (by_ld) lsense <= 1;
    else therm <= 0;
    wake_at = cyc;
  endtask
  // elapsed time from wake to a rising output, within one tick plus 8 cycles
  task timing(input int idx, input int unsigned ms);
    int unsigned el;
    while (obs[idx] !== 1'b1) @(posedge pclk);
    el = cyc - wake_at;
    chk(32'(el >= ms * MS && el <= ms * MS + MS + 8), 32'h0000_0001);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    apb(0, ADDR_NVCFG, 32'h0000_0000);
    chk(rd, 32'(NVCFG_RESET));
    apb(0, ADDR_ALSEL, 32'h0000_0000);
    chk(rd, 32'(ALSEL_RESET));
    apb(0, 12'h040, 32'h0000_0000);
    chk({31'b0, err}, 32'h0000_0001);
  endtask
  task t_slow;
    apb(1, ADDR_MASK, 32'h0000_0001);
    wake(0);
    timing(0, 20);
    timing(1, 23);
    timing(2, 282);
    apb(0, ADDR_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_060F, 32'h0000_060F);
    apb(0, ADDR_NVCFG, 32'h0000_0000);
    chk(rd, 32'h0000_0006);
    chk({31'b0, irq}, 32'h0000_0001);
    apb(1, ADDR_IRQ, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk({31'b0, irq}, 32'h0000_0000);
  endtask
  task t_dsg;
    int   pulses;
    logic prev;
    pulses = 0;
    prev = 0;
    apb(1, ADDR_CTRL, 32'h0000_0001);
    repeat (PW + 40) begin
      @(posedge pclk);
      if (pull && !prev) pulses++;
      prev = pull;
    end
    chk(32'(pulses >= 2), 32'h0000_0001);
    chk({30'b0, hiz, near}, 32'h0000_0003);
    apb(0, ADDR_IRQ, 32'h0000_0000);
    chk(rd & 32'h0000_0004, 32'h0000_0004);
  endtask
  task t_chg;
    apb(1, ADDR_CTRL, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk({30'b0, charge_gate_drive, fets_on}, 32'h0000_0002);
  endtask
  task t_fast;
    do_reset(3'b111);
    apb(1, ADDR_ALSEL, 32'h0000_0002);
    wake(1);
    timing(1, 58);
    apb(1, ADDR_ALSEL, 32'h0000_0008);
    repeat (2) @(posedge pclk);
    timing(1, 129);
    timing(2, 284);
  endtask
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; presetn = 0;
    therm = 1; lsense = 0; nv_valid = 1; nv_cfg = 3'b110;
    do_reset(3'b110);
    t_regs();
    t_slow();
    t_dsg();
    t_chg();
    t_fast();
    wrap_up();
  end
endmodule
